//--- inc/pcd_pkg.sv
// pcd_pkg: register map, field positions and reset values of the divider pair
// assumes an 8-bit register port with byte-wide registers at word addresses
package pcd_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_DIV = 2;
  localparam int unsigned CNT_W = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] DIV0_HIGH_LOW_COUNTS = 10'h190;
  localparam logic [ADDR_W-1:0] DIV0_CONTROL_PHASE   = 10'h191;
  localparam logic [ADDR_W-1:0] DIV0_ROUTE_DUTY      = 10'h192;
  localparam logic [ADDR_W-1:0] DIV1_HIGH_LOW_COUNTS = 10'h196;
  localparam logic [ADDR_W-1:0] DIV1_CONTROL_PHASE   = 10'h197;
  localparam logic [ADDR_W-1:0] DIV1_ROUTE_DUTY      = 10'h198;
  localparam logic [ADDR_W-1:0] PAIR_STATUS          = 10'h193;

  // counts register fields
  localparam int unsigned LOW_CNT_LSB  = 4;
  localparam int unsigned HIGH_CNT_LSB = 0;
  // control/phase register fields
  localparam int unsigned BYPASS_BIT   = 7;
  localparam int unsigned NOSYNC_BIT   = 6;
  localparam int unsigned FORCE_BIT    = 5;
  localparam int unsigned START_BIT    = 4;
  localparam int unsigned PHASE_LSB    = 0;
  // route/duty register fields
  localparam int unsigned DIRECT_BIT   = 1;
  localparam int unsigned DCC_OFF_BIT  = 0;
  // status register fields
  localparam int unsigned STAT_LVL_LSB = 0;
  localparam int unsigned STAT_RUN_LSB = 2;
  localparam int unsigned STAT_HLD_LSB = 4;

  // source-select codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h2;

  // reset values
  localparam logic [DATA_W-1:0] COUNTS_RST  = 8'h00;
  localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;
  localparam logic [DATA_W-1:0] ROUTE_RST   = 8'h00;

  typedef enum logic [1:0] {
    DV_HOLD,
    DV_PHASE,
    DV_RUN
  } pcd_div_state_e;

endpackage

//--- hw/pcd_divider_pair.sv
// pcd_divider_pair: two programmable channel dividers feeding two output pairs
// assumes oscillator, external clock and sync pins are slower than clk_i / 2
//
// Notes on behaviour
// (R01) Output stays low for low-count field plus one input-clock cycles.
// (R02) Output stays high for high-count field plus one input-clock cycles.
// (R03) Bypass powers the divider down and passes its input clock straight out.
// (R04) No-sync clear obeys chip sync; set keeps the divider counting through chip sync.
// (R05) Software must set no-sync whenever it wants a forced static output.
// (R06) Force-level bit gives static output: zero low, one high.
// (R07) Start-level bit picks whether divided clock begins low or high.
// (R08) Low nibble of control register sets coarse phase offset in input cycles.
// (R09) Direct-route clear: first output pair driven from first divider.
// (R10) Direct-route set with source code 10: oscillator straight to the pair.
// (R11) Direct-route set with source code 00: external clock straight to the pair.
// (R12) Direct-route set with source code 01: routing unchanged, divider drives.
// (R13) Duty-correction bit zero enables correction, one disables it.
// (R14) First divider registers at 190, 191 and 192 hex.
// (R15) Second divider same layout at 196, 197, 198; drives second pair.
// (R16) After sync release, obeying dividers apply phase then restart at start level.
`timescale 1ns/1ps

module pcd_divider_pair (
  input  wire logic                          clk_i,              // 125 MHz system clock
  input  wire logic                          rst_i,              // sync reset, active high
  input  wire logic [pcd_pkg::ADDR_W-1:0]    reg_addr_i,         // register address
  input  wire logic [pcd_pkg::DATA_W-1:0]    reg_wdata_i,        // register write data
  input  wire logic                          reg_wr_i,           // write strobe
  input  wire logic                          reg_rd_i,           // read strobe
  output logic      [pcd_pkg::DATA_W-1:0]    reg_rdata_o,        // read data, cycle after
  input  wire logic                          osc_clk_i,          // oscillator clock pin
  input  wire logic                          ext_clk_i,          // external clock pin
  input  wire logic                          sync_n_i,           // chip sync pin, active low
  input  wire logic [1:0]                    src_sel_i,          // source-select field
  output logic                               pecl_pair_a_first_o,  // pair a, first output
  output logic                               pecl_pair_a_second_o, // pair a, second output
  output logic                               pecl_pair_b_first_o,  // pair b, first output
  output logic                               pecl_pair_b_second_o, // pair b, second output
  output logic      [pcd_pkg::NUM_DIV-1:0]   duty_correction_disable_o, // per divider
  output logic      [pcd_pkg::NUM_DIV-1:0]   divider_power_down_o       // per divider
);
  import pcd_pkg::*;

  typedef struct packed {
    logic [NUM_DIV-1:0][DATA_W-1:0] counts;
    logic [NUM_DIV-1:0][DATA_W-1:0] control;
    logic [NUM_DIV-1:0][DATA_W-1:0] route;
    logic [DATA_W-1:0]              rdata;
    logic [1:0]                     osc_sync;
    logic [1:0]                     ext_sync;
    logic [1:0]                     syn_sync;
    logic                           src_prev;
    pcd_div_state_e [NUM_DIV-1:0]   st;
    logic [NUM_DIV-1:0][CNT_W-1:0]  cnt;
    logic [NUM_DIV-1:0][CNT_W-1:0]  ph;
    logic [NUM_DIV-1:0]             lvl;
    logic [NUM_DIV-1:0]             pair;
  } pcd_state_s;

  pcd_state_s s_q;
  pcd_state_s s_d;

  logic                           osc_lvl;
  logic                           ext_lvl;
  logic                           sync_act;
  logic                           src_lvl;
  logic                           tick;
  logic [NUM_DIV-1:0]             bypass;
  logic [NUM_DIV-1:0]             nosync;
  logic [NUM_DIV-1:0]             force_lvl;
  logic [NUM_DIV-1:0]             start_lvl;
  logic [NUM_DIV-1:0]             direct;
  logic [NUM_DIV-1:0][CNT_W-1:0]  phase;
  logic [NUM_DIV-1:0][CNT_W-1:0]  low_cnt;
  logic [NUM_DIV-1:0][CNT_W-1:0]  high_cnt;
  logic [NUM_DIV-1:0]             route_osc;
  logic [NUM_DIV-1:0]             route_ext;
  logic [NUM_DIV-1:0]             show_force;
  logic [NUM_DIV-1:0]             held;
  logic [NUM_DIV-1:0]             wr_counts;
  logic [NUM_DIV-1:0]             wr_control;
  logic [NUM_DIV-1:0]             wr_route;
  logic [DATA_W-1:0]              status;

  // refuse shapes that the fixed field decode below cannot serve
  if (NUM_DIV != 2) begin : g_num_div_chk
    $error("divider pair logic serves exactly two dividers");
  end
  if (DATA_W != 8) begin : g_data_w_chk
    $error("registers must be byte wide");
  end
  if (CNT_W != 4) begin : g_cnt_w_chk
    $error("count and phase fields must be four bits");
  end
  if (ADDR_W < 9) begin : g_addr_w_chk
    $error("address too narrow for the register map");
  end
  if (LOW_CNT_LSB + CNT_W > DATA_W) begin : g_low_fld_chk
    $error("low-count field outside its register");
  end
  if (HIGH_CNT_LSB + CNT_W > DATA_W) begin : g_high_fld_chk
    $error("high-count field outside its register");
  end
  if (PHASE_LSB + CNT_W > DATA_W) begin : g_phase_fld_chk
    $error("phase field outside its register");
  end
  if (BYPASS_BIT >= DATA_W) begin : g_bypass_fld_chk
    $error("bypass bit outside its register");
  end
  if (NOSYNC_BIT >= DATA_W) begin : g_nosync_fld_chk
    $error("no-sync bit outside its register");
  end
  if (FORCE_BIT >= DATA_W) begin : g_force_fld_chk
    $error("force bit outside its register");
  end
  if (START_BIT >= DATA_W) begin : g_start_fld_chk
    $error("start bit outside its register");
  end
  if (DIRECT_BIT >= DATA_W) begin : g_direct_fld_chk
    $error("direct-route bit outside its register");
  end
  if (DCC_OFF_BIT >= DATA_W) begin : g_dcc_fld_chk
    $error("duty-correction bit outside its register");
  end
  if (STAT_LVL_LSB + NUM_DIV > DATA_W) begin : g_stat_lvl_chk
    $error("status level field outside the status byte");
  end
  if (STAT_RUN_LSB + NUM_DIV > DATA_W) begin : g_stat_run_chk
    $error("status run field outside the status byte");
  end
  if (STAT_HLD_LSB + NUM_DIV > DATA_W) begin : g_stat_hld_chk
    $error("status hold field outside the status byte");
  end

  // second synchroniser stages only
  assign osc_lvl  = s_q.osc_sync[1];
  assign ext_lvl  = s_q.ext_sync[1];
  assign sync_act = ~s_q.syn_sync[1];

  // divider input follows the source select
  assign src_lvl = (src_sel_i == SRC_OSC) ? osc_lvl : ext_lvl;
  assign tick    = src_lvl & ~s_q.src_prev;

  always_comb begin
    for (int i = 0; i < NUM_DIV; i++) begin
      bypass[i]    = s_q.control[i][BYPASS_BIT];
      nosync[i]    = s_q.control[i][NOSYNC_BIT];
      force_lvl[i] = s_q.control[i][FORCE_BIT];
      start_lvl[i] = s_q.control[i][START_BIT];
      phase[i]     = s_q.control[i][PHASE_LSB +: CNT_W];        // R08
      low_cnt[i]   = s_q.counts[i][LOW_CNT_LSB +: CNT_W];
      high_cnt[i]  = s_q.counts[i][HIGH_CNT_LSB +: CNT_W];
      direct[i]    = s_q.route[i][DIRECT_BIT];
      // direct routing wins over every divider setting
      route_osc[i]  = direct[i] && (src_sel_i == SRC_OSC);
      route_ext[i]  = direct[i] && (src_sel_i == SRC_EXT);
      // static level only while sync is asserted and ignored
      show_force[i] = nosync[i] && sync_act;
      held[i]       = (s_q.st[i] == DV_HOLD);
    end
  end

  // one write enable per register and divider
  always_comb begin
    wr_counts  = '0;
    wr_control = '0;
    wr_route   = '0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        DIV0_HIGH_LOW_COUNTS: wr_counts[0]  = 1'b1;   // R14
        DIV0_CONTROL_PHASE:   wr_control[0] = 1'b1;   // R14
        DIV0_ROUTE_DUTY:      wr_route[0]   = 1'b1;   // R14
        DIV1_HIGH_LOW_COUNTS: wr_counts[1]  = 1'b1;   // R15
        DIV1_CONTROL_PHASE:   wr_control[1] = 1'b1;   // R15
        DIV1_ROUTE_DUTY:      wr_route[1]   = 1'b1;   // R15
        default: begin
        end
      endcase
    end
  end

  // status byte: levels, running and held dividers
  always_comb begin
    status = '0;
    for (int i = 0; i < NUM_DIV; i++) begin
      status[STAT_LVL_LSB + i] = s_q.lvl[i];
      status[STAT_RUN_LSB + i] = (s_q.st[i] == DV_RUN);
      status[STAT_HLD_LSB + i] = held[i];
    end
  end

  always_comb begin
    s_d = s_q;

    s_d.osc_sync = {s_q.osc_sync[0], osc_clk_i};
    s_d.ext_sync = {s_q.ext_sync[0], ext_clk_i};
    s_d.syn_sync = {s_q.syn_sync[0], sync_n_i};
    s_d.src_prev = src_lvl;

    // register writes, visible to the dividers one cycle later
    for (int i = 0; i < NUM_DIV; i++) begin
      if (wr_counts[i]) begin
        s_d.counts[i] = reg_wdata_i;
      end
      if (wr_control[i]) begin
        s_d.control[i] = reg_wdata_i;
      end
      if (wr_route[i]) begin
        s_d.route[i] = reg_wdata_i;
      end
    end

    // register reads, answered the next cycle
    s_d.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        DIV0_HIGH_LOW_COUNTS: s_d.rdata = s_q.counts[0];
        DIV0_CONTROL_PHASE:   s_d.rdata = s_q.control[0];
        DIV0_ROUTE_DUTY:      s_d.rdata = s_q.route[0];
        DIV1_HIGH_LOW_COUNTS: s_d.rdata = s_q.counts[1];
        DIV1_CONTROL_PHASE:   s_d.rdata = s_q.control[1];
        DIV1_ROUTE_DUTY:      s_d.rdata = s_q.route[1];
        PAIR_STATUS:          s_d.rdata = status;
        default: s_d.rdata = '0;
      endcase
    end

    for (int i = 0; i < NUM_DIV; i++) begin
      if (bypass[i]) begin
        // powered down: counter parked at its restart point
        s_d.st[i]  = DV_RUN;                                    // R03
        s_d.cnt[i] = '0;
        s_d.lvl[i] = start_lvl[i];
      end else if (!nosync[i] && sync_act) begin
        s_d.st[i]  = DV_HOLD;                                   // R04
        s_d.cnt[i] = '0;
        s_d.lvl[i] = start_lvl[i];                              // R07
      end else begin
        case (s_q.st[i])
          DV_HOLD: begin
            // sync released: apply phase offset first
            s_d.cnt[i] = '0;
            s_d.lvl[i] = start_lvl[i];
            s_d.ph[i]  = phase[i];                              // R16
            s_d.st[i]  = (phase[i] == '0) ? DV_RUN : DV_PHASE;  // R16
          end
          DV_PHASE: begin
            if (tick) begin
              s_d.ph[i] = s_q.ph[i] - 1'b1;                     // R08
              if (s_q.ph[i] == 4'h1) begin
                s_d.st[i] = DV_RUN;
              end
            end
          end
          DV_RUN: begin
            if (tick) begin
              if (s_q.lvl[i] && s_q.cnt[i] == high_cnt[i]) begin
                s_d.lvl[i] = 1'b0;                              // R02
                s_d.cnt[i] = '0;
              end else if (!s_q.lvl[i] && s_q.cnt[i] == low_cnt[i]) begin
                s_d.lvl[i] = 1'b1;                              // R01
                s_d.cnt[i] = '0;
              end else begin
                s_d.cnt[i] = s_q.cnt[i] + 1'b1;
              end
            end
          end
          default: s_d.st[i] = DV_HOLD;
        endcase
      end

      // output selection for this divider's pair
      // code 01 falls through, so the divider keeps the pair
      if (route_osc[i]) begin
        s_d.pair[i] = osc_lvl;                                  // R10
      end else if (route_ext[i]) begin
        s_d.pair[i] = ext_lvl;                                  // R11
      end else if (bypass[i]) begin
        // bypass passes the synchronised source, not the raw pin
        s_d.pair[i] = src_lvl;                                  // R03
      end else if (show_force[i]) begin
        // static level while sync is asserted and ignored; counter runs on below
        s_d.pair[i] = force_lvl[i];                             // R06 R05
      end else begin
        s_d.pair[i] = s_q.lvl[i];                               // R09 R12
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.counts   <= {NUM_DIV{COUNTS_RST}};
      s_q.control  <= {NUM_DIV{CONTROL_RST}};
      s_q.route    <= {NUM_DIV{ROUTE_RST}};
      s_q.rdata    <= '0;
      s_q.osc_sync <= '0;
      s_q.ext_sync <= '0;
      s_q.syn_sync <= 2'h3;
      s_q.src_prev <= 1'b0;
      for (int i = 0; i < NUM_DIV; i++) begin
        s_q.st[i]  <= DV_HOLD;
      end
      s_q.cnt      <= '0;
      s_q.ph       <= '0;
      s_q.lvl      <= '0;
      s_q.pair     <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o          = s_q.rdata;
  assign pecl_pair_a_first_o  = s_q.pair[0];                    // R09
  assign pecl_pair_a_second_o = s_q.pair[0];
  assign pecl_pair_b_first_o  = s_q.pair[1];                    // R15
  assign pecl_pair_b_second_o = s_q.pair[1];

  always_comb begin
    for (int i = 0; i < NUM_DIV; i++) begin
      duty_correction_disable_o[i] = s_q.route[i][DCC_OFF_BIT]; // R13
      divider_power_down_o[i]      = bypass[i];                 // R03
    end
  end

endmodule

//--- tb/pcd_divider_pair_chk.sv
// pcd_divider_pair_chk: port-level assertions for the divider pair
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module pcd_divider_pair_chk
  import pcd_pkg::*;
(
  input wire logic              clk_i,            // clock
  input wire logic              rst_i,            // reset
  input wire logic [ADDR_W-1:0] reg_addr_i,       // address
  input wire logic [DATA_W-1:0] reg_wdata_i,      // write data
  input wire logic              reg_wr_i,         // write strobe
  input wire logic              reg_rd_i,         // read strobe
  input wire logic [DATA_W-1:0] reg_rdata_o,      // read data
  input wire logic              pecl_pair_a_first_o,  // pair a
  input wire logic              pecl_pair_a_second_o, // pair a
  input wire logic              pecl_pair_b_first_o,  // pair b
  input wire logic              pecl_pair_b_second_o, // pair b
  input wire logic [1:0]        duty_correction_disable_o, // dcc off
  input wire logic [1:0]        divider_power_down_o       // bypass
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside read cycle");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 10'h1FF |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_readback: assert property ((reg_wr_i && reg_addr_i == DIV0_HIGH_LOW_COUNTS) ##1
    (reg_rd_i && reg_addr_i == DIV0_HIGH_LOW_COUNTS) |=> reg_rdata_o == $past(reg_wdata_i, 2))
    else $error("counts readback mismatch");
  chk_bypass_pd0: assert property (reg_wr_i && reg_addr_i == DIV0_CONTROL_PHASE
    |=> divider_power_down_o[0] == $past(reg_wdata_i[7]))
    else $error("divider 0 power down wrong");
  chk_bypass_pd1: assert property (reg_wr_i && reg_addr_i == DIV1_CONTROL_PHASE
    |=> divider_power_down_o[1] == $past(reg_wdata_i[7]))
    else $error("divider 1 power down wrong");
  chk_pd_stable: assert property (!reg_wr_i |=> $stable(divider_power_down_o))
    else $error("power down changed without write");
  chk_dcc_bit: assert property (reg_wr_i && reg_addr_i == DIV0_ROUTE_DUTY
    |=> duty_correction_disable_o[0] == $past(reg_wdata_i[0]))
    else $error("duty correction bit wrong");
  chk_pair_a_same: assert property (pecl_pair_a_first_o == pecl_pair_a_second_o)
    else $error("pair a outputs differ");
  chk_pair_b_same: assert property (pecl_pair_b_first_o == pecl_pair_b_second_o)
    else $error("pair b outputs differ");
endmodule
bind pcd_divider_pair pcd_divider_pair_chk u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pecl_pair_a_first_o(pecl_pair_a_first_o),
  .pecl_pair_a_second_o(pecl_pair_a_second_o), .pecl_pair_b_first_o(pecl_pair_b_first_o),
  .pecl_pair_b_second_o(pecl_pair_b_second_o),
  .duty_correction_disable_o(duty_correction_disable_o),
  .divider_power_down_o(divider_power_down_o));

//--- tb/pcd_divider_pair_tb.sv
// pcd_divider_pair_tb: register and divider output checks
// assumes source pins far slower than clk_i; ext half period 4 clk, osc 6 clk
`timescale 1ns/1ps
module pcd_divider_pair_tb;
  import pcd_pkg::*;
  logic              clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic              osc_clk_i = 1'b0, ext_clk_i = 1'b0, sync_n_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 10'h000;
  logic [DATA_W-1:0] reg_wdata_i = 8'h00, reg_rdata_o;
  logic [1:0]        src_sel_i = 2'h0, dcc_o, pd_o;
  logic              pa0, pa1, pb0, pb1;
  int                failures = 0, n_tests = 0, n;
  localparam logic [9:0] RA [6] = '{10'h190, 10'h191, 10'h192, 10'h196, 10'h197, 10'h198};
  always #4 clk_i = ~clk_i;
  always #32 ext_clk_i = ~ext_clk_i;
  always #48 osc_clk_i = ~osc_clk_i;
  pcd_divider_pair u_pcd_divider_pair (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .osc_clk_i(osc_clk_i), .ext_clk_i(ext_clk_i),
    .sync_n_i(sync_n_i), .src_sel_i(src_sel_i), .pecl_pair_a_first_o(pa0),
    .pecl_pair_a_second_o(pa1), .pecl_pair_b_first_o(pb0), .pecl_pair_b_second_o(pb1),
    .duty_correction_disable_o(dcc_o), .divider_power_down_o(pd_o));
  task automatic test_done();
    $display("checks=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, e);
    @(posedge clk_i);
  endtask
  // counts cycles until the chosen pair output shows level v
  task automatic wlev(input logic b, input logic v);
    n = 0;
    while ((b ? pb0 : pa0) !== v) begin
      @(posedge clk_i);
      #1 n++;
      if (n > 400) begin
        failures++;
        test_done();
      end
    end
  endtask
  task automatic meas(input logic b, input int hi, input int lo);
    wlev(b, 1'b0);
    wlev(b, 1'b1);
    wlev(b, 1'b0);
    check(8'(n), 8'(hi));
    wlev(b, 1'b1);
    check(8'(n), 8'(lo));
  endtask
  initial begin
    #400000 failures++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (RA[i]) rd(RA[i], 8'h00);
    foreach (RA[i]) wr(RA[i], 8'(8'h5A + i));
    foreach (RA[i]) rd(RA[i], 8'(8'h5A + i));
    rd(10'h1FF, 8'h00);
    reg_addr_i <= DIV0_HIGH_LOW_COUNTS;
    reg_wdata_i <= 8'hC3;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, 8'hC3);
    @(posedge clk_i);
    foreach (RA[i]) wr(RA[i], 8'h00);
    wr(DIV0_HIGH_LOW_COUNTS, 8'h21);
    rd(DIV0_HIGH_LOW_COUNTS, 8'h21);
    wr(DIV1_HIGH_LOW_COUNTS, 8'h10);
    meas(1'b0, 16, 24);
    meas(1'b1, 8, 16);
    wr(DIV0_ROUTE_DUTY, 8'h03);
    src_sel_i <= 2'h1;
    meas(1'b0, 16, 24);
    src_sel_i <= 2'h2;
    meas(1'b0, 6, 6);
    src_sel_i <= 2'h0;
    meas(1'b0, 4, 4);
    check({6'h00, dcc_o}, 8'h01);
    wr(DIV0_ROUTE_DUTY, 8'h00);
    wr(DIV0_CONTROL_PHASE, 8'h80);
    check({6'h00, pd_o}, 8'h01);
    meas(1'b0, 4, 4);
    wr(DIV0_CONTROL_PHASE, 8'h60);
    sync_n_i <= 1'b0;
    wlev(1'b0, 1'b1);
    repeat (40) @(posedge clk_i);
    #1 check({7'h00, pa0}, 8'h01);
    wr(DIV0_CONTROL_PHASE, 8'h40);
    repeat (40) @(posedge clk_i);
    #1 check({7'h00, pa0}, 8'h00);
    wr(DIV0_CONTROL_PHASE, 8'h10);
    repeat (40) @(posedge clk_i);
    #1 check({7'h00, pa0}, 8'h01);
    wr(DIV0_CONTROL_PHASE, 8'h00);
    repeat (40) @(posedge clk_i);
    #1 check({7'h00, pa0}, 8'h00);
    sync_n_i <= 1'b1;
    meas(1'b0, 16, 24);
    wr(DIV0_HIGH_LOW_COUNTS, 8'h00);
    wr(DIV1_HIGH_LOW_COUNTS, 8'h00);
    wr(DIV0_CONTROL_PHASE, 8'h03);
    sync_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    rd(PAIR_STATUS, 8'h30);
    sync_n_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    wlev(1'b1, 1'b0);
    wlev(1'b1, 1'b1);
    check({7'h00, pa0}, 8'h00);
    test_done();
  end
endmodule
